/* File: design/srbf_consts.svh */
// constants for the secure region and boot recovery block
`ifndef SRBF_CONSTS_SVH
`define SRBF_CONSTS_SVH
`define SECURE_BYTES 1024
`define REGION_BYTES 32
`define REGION_COUNT 32
`define RANDOM_BYTES 16
`define LOCK_BASE 16
`define ADDR_BYTES 4
`define READ_LATENCY 2
`define STATUS_VOL_ADDR 32'h0080_0000
`define OP_READ_STATUS 8'h05
`define OP_READ_ANY 8'h65
`define OP_WRITE_ANY 8'h71
`define OP_WRITE_ENABLE 8'h06
`define OP_PROG_SECURE 8'h42
`define OP_READ_SECURE 8'h4B
`define OP_ERASE_SECURE 8'h44
`define CLK_PERIOD_NS 10
`define NV_WRITE_NS 2000
`define NV_WRITE_CYC (`NV_WRITE_NS / `CLK_PERIOD_NS)
`endif

/* File: design/srbf_pkg.sv */
// types for the secure region and boot recovery block
package srbf_pkg;
	typedef enum logic [1:0] {
		mode_normal,
		mode_init_fail,
		mode_cfg_corrupt
	} boot_mode_t;
	typedef enum logic [2:0] {
		ph_cmd,
		ph_addr,
		ph_dummy,
		ph_data,
		ph_ignore
	} phase_t;
	typedef struct packed {
		logic config_write_protect_select;
		logic program_error_flag;
		logic erase_error_flag;
		logic [2:0] block_protect_size;
		logic write_enable_latch;
		logic ready_busy_flag;
	} status_t;
endpackage : srbf_pkg

/* File: design/secure_region_boot.sv */
// serial flash secure region with boot failure recovery
`timescale 1ns/1ps
`include "srbf_consts.svh"
module secure_region_boot #(
	parameter logic [127:0] RANDOM_VALUE = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0,
	parameter int NV_WRITE_CYCLES = `NV_WRITE_CYC
) (
	input wire logic clock_in, // system clock
	input wire logic rst_n_in, // power-on reset
	input wire logic hw_reset_n_in, // hardware reset pin
	input wire logic sck_in, // serial clock pin
	input wire logic cs_n_in, // chip select pin
	input wire logic [3:0] dq_in, // data pins in
	input wire logic quad_mode_in, // four-lane protocol chosen
	input wire logic init_fail_in, // controller init failed
	input wire logic cfg_corrupt_in, // stored config bad at boot
	input wire logic [2:0] block_protect_size_in, // protect config
	output logic [3:0] dq_out, // data pins out
	output logic [3:0] dq_oe_out, // data pin enables
	output srbf_pkg::status_t status_out, // volatile status
	output srbf_pkg::boot_mode_t boot_mode_out // boot mode
);
	import srbf_pkg::*;

	logic [2:0] sck_r;
	logic [2:0] cs_r;
	logic [1:0] hwr_r;
	logic [3:0] dq_s1_r;
	logic [3:0] dq_s2_r;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sck_r <= 3'h0;
			cs_r <= 3'h7;
			hwr_r <= 2'h3;
			dq_s1_r <= 4'h0;
			dq_s2_r <= 4'h0;
		end else begin
			sck_r <= {sck_r[1:0], sck_in};
			cs_r <= {cs_r[1:0], cs_n_in};
			hwr_r <= {hwr_r[0], hw_reset_n_in};
			dq_s1_r <= dq_in;
			dq_s2_r <= dq_s1_r;
		end
	end

	logic hwr_act;
	logic frame_on;
	logic rise;
	logic fall;
	logic cs_end;
	logic cs_start;
	assign hwr_act = ~hwr_r[1];
	assign frame_on = ~cs_r[1] & ~hwr_act;
	assign rise = sck_r[1] & ~sck_r[2];
	assign fall = ~sck_r[1] & sck_r[2];
	assign cs_end = cs_r[1] & ~cs_r[2];
	assign cs_start = ~cs_r[1] & cs_r[2];

	phase_t phase_r;
	boot_mode_t mode_r;
	status_t status_r;
	logic [7:0] cmd_r;
	logic [7:0] shift_r;
	logic [3:0] bcnt_r;
	logic [1:0] acnt_r;
	logic [1:0] dcnt_r;
	logic [31:0] addr_r;
	logic quad_r;
	logic [7:0] out_r;
	logic prg_r;
	logic ers_r;
	logic stuck_r;
	logic wel_r;
	logic wp_r;
	logic corrupt_r;
	logic boot_pend_r;
	logic [15:0] nv_cnt_r;
	logic [7:0] mem [0:`SECURE_BYTES-1];

	logic [7:0] in_byte;
	logic [3:0] bcnt_inc;
	logic shifting;
	logic byte_done;
	logic is_read;
	logic restricted;
	phase_t cmd_phase;
	assign in_byte = quad_r ? {shift_r[3:0], dq_s2_r} : {shift_r[6:0], dq_s2_r[0]};
	assign bcnt_inc = bcnt_r + (quad_r ? 4'h4 : 4'h1);
	assign shifting = phase_r == ph_cmd || phase_r == ph_addr || phase_r == ph_data;
	assign byte_done = frame_on & rise & shifting & (bcnt_inc == 4'h8);
	assign is_read = cmd_r == `OP_READ_STATUS || cmd_r == `OP_READ_ANY
		|| cmd_r == `OP_READ_SECURE;
	assign restricted = mode_r == mode_init_fail || stuck_r;

	// phase taken after the command byte
	always_comb begin
		cmd_phase = ph_ignore;
		if (in_byte == `OP_READ_STATUS) begin
			cmd_phase = ph_data;
		end else if (in_byte == `OP_READ_ANY) begin
			cmd_phase = ph_addr;
		end else if (!restricted) begin
			case (in_byte)
				`OP_READ_SECURE, `OP_PROG_SECURE: cmd_phase = ph_addr;
				`OP_ERASE_SECURE, `OP_WRITE_ANY: cmd_phase = ph_addr;
				default: cmd_phase = ph_ignore;
			endcase
		end
	end

	logic [9:0] sec_a;
	logic [9:0] ers_a;
	logic [31:0] lock_vec;
	logic prog_stb;
	logic prog_rnd;
	logic prog_lock;
	logic ers_stb;
	logic ers_rnd;
	logic wrar_stb;
	logic we_stb;
	assign sec_a = addr_r[9:0];
	assign ers_a = {addr_r[1:0], in_byte};
	assign lock_vec = {mem[`LOCK_BASE+3], mem[`LOCK_BASE+2], mem[`LOCK_BASE+1],
		mem[`LOCK_BASE]};
	assign prog_stb = byte_done & phase_r == ph_data & cmd_r == `OP_PROG_SECURE & wel_r;
	assign prog_rnd = sec_a < 10'(`RANDOM_BYTES);
	assign prog_lock = ~lock_vec[sec_a[9:5]];
	assign ers_stb = byte_done & phase_r == ph_addr & acnt_r == 2'h3
		& cmd_r == `OP_ERASE_SECURE & wel_r;
	assign ers_rnd = ers_a < 10'(`RANDOM_BYTES);
	assign wrar_stb = byte_done & phase_r == ph_data & cmd_r == `OP_WRITE_ANY & wel_r;
	assign we_stb = byte_done & phase_r == ph_cmd & in_byte == `OP_WRITE_ENABLE
		& !restricted;

	// serial protocol sequencing
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			phase_r <= ph_cmd;
			cmd_r <= 8'h00;
			shift_r <= 8'h00;
			bcnt_r <= 4'h0;
			acnt_r <= 2'h0;
			dcnt_r <= 2'h0;
			addr_r <= 32'h0;
			quad_r <= 1'b0;
		end else if (!frame_on) begin
			phase_r <= ph_cmd;
			bcnt_r <= 4'h0;
			acnt_r <= 2'h0;
			dcnt_r <= 2'h0;
		end else begin
			if (cs_start) begin
				quad_r <= quad_mode_in & (mode_r == mode_normal);
			end
			if (rise && shifting) begin
				shift_r <= in_byte;
				bcnt_r <= (bcnt_inc == 4'h8) ? 4'h0 : bcnt_inc;
			end
			case (phase_r)
				ph_cmd: begin
					if (byte_done) begin
						cmd_r <= in_byte;
						phase_r <= cmd_phase;
					end
				end
				ph_addr: begin
					if (byte_done) begin
						addr_r <= {addr_r[23:0], in_byte};
						acnt_r <= acnt_r + 2'h1;
						if (acnt_r == 2'(`ADDR_BYTES-1)) begin
							if (is_read) begin
								phase_r <= ph_dummy;
							end else if (cmd_r == `OP_ERASE_SECURE) begin
								phase_r <= ph_ignore;
							end else begin
								phase_r <= ph_data;
							end
						end
					end
				end
				ph_dummy: begin
					if (rise) begin
						dcnt_r <= dcnt_r + 2'h1;
						if (dcnt_r == 2'(`READ_LATENCY-1)) begin
							phase_r <= ph_data;
						end
					end
				end
				ph_data: begin
					if (byte_done) begin
						addr_r <= addr_r + 32'h1;
					end
				end
				ph_ignore: phase_r <= ph_ignore;
				default: phase_r <= ph_cmd;
			endcase
		end
	end

	// read data source
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'hFF;
		case (cmd_r)
			`OP_READ_STATUS: rd_byte = status_r;
			`OP_READ_ANY: begin
				if (addr_r == `STATUS_VOL_ADDR) begin
					rd_byte = status_r;
				end
			end
			`OP_READ_SECURE: begin
				if (prog_rnd) begin
					rd_byte = RANDOM_VALUE[{sec_a[3:0], 3'h0} +: 8];
				end else begin
					rd_byte = mem[sec_a];
				end
			end
			default: rd_byte = 8'hFF;
		endcase
	end

	logic [7:0] out_nxt;
	logic rd_phase;
	assign rd_phase = frame_on & phase_r == ph_data & is_read;
	always_comb begin
		out_nxt = out_r;
		if (fall && rd_phase) begin
			if (bcnt_r == 4'h0) begin
				out_nxt = rd_byte;
			end else begin
				out_nxt = quad_r ? {out_r[3:0], 4'h0} : {out_r[6:0], 1'b0};
			end
		end
	end

	// output lanes
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_r <= 8'h00;
			dq_out <= 4'h0;
			dq_oe_out <= 4'h0;
		end else begin
			out_r <= out_nxt;
			dq_out <= quad_r ? out_nxt[7:4] : {2'h0, out_nxt[7], 1'b0};
			dq_oe_out <= rd_phase ? (quad_r ? 4'hF : 4'h2) : 4'h0;
		end
	end

	// one-time-programmable store, program only clears bits
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `SECURE_BYTES; i++) begin
				mem[i] <= 8'hFF;
			end
		end else if (prog_stb && !prog_rnd && !prog_lock && !stuck_r && !hwr_act) begin
			mem[sec_a] <= mem[sec_a] & in_byte;
		end
	end

	// error flags, write enable, stall
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			prg_r <= 1'b0;
			ers_r <= 1'b0;
			stuck_r <= 1'b0;
			wel_r <= 1'b0;
			wp_r <= 1'b0;
		end else if (hwr_act) begin
			prg_r <= 1'b0;
			ers_r <= 1'b0;
			stuck_r <= 1'b0;
			wel_r <= 1'b0;
		end else begin
			if (prog_stb && (prog_rnd || prog_lock)) begin
				prg_r <= 1'b1;
			end
			if (ers_stb && ers_rnd) begin
				ers_r <= 1'b1;
			end
			if ((prog_stb && prog_rnd) || (ers_stb && ers_rnd)) begin
				stuck_r <= 1'b1;
			end
			if (we_stb) begin
				wel_r <= 1'b1;
			end else if (cs_end && (cmd_r == `OP_PROG_SECURE || cmd_r == `OP_ERASE_SECURE
				|| cmd_r == `OP_WRITE_ANY)) begin
				wel_r <= 1'b0;
			end
			if (wrar_stb && addr_r == `STATUS_VOL_ADDR) begin
				wp_r <= in_byte[7];
			end
		end
	end

	// nonvolatile write and corruption marker
	logic nv_busy;
	assign nv_busy = nv_cnt_r != 16'h0;
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			nv_cnt_r <= 16'h0;
			corrupt_r <= 1'b0;
		end else if (hwr_act) begin
			nv_cnt_r <= 16'h0;
			if (nv_busy) begin
				corrupt_r <= 1'b1;
			end
		end else if (wrar_stb && addr_r != `STATUS_VOL_ADDR && !nv_busy) begin
			nv_cnt_r <= 16'(NV_WRITE_CYCLES);
		end else if (nv_busy) begin
			nv_cnt_r <= nv_cnt_r - 16'h1;
			if (nv_cnt_r == 16'h1) begin
				corrupt_r <= 1'b0;
			end
		end
	end

	// boot mode picked after power-on and each hardware reset
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			boot_pend_r <= 1'b1;
			mode_r <= mode_normal;
		end else begin
			boot_pend_r <= 1'b0;
			if (boot_pend_r || hwr_act) begin
				if (init_fail_in) begin
					mode_r <= mode_init_fail;
				end else if (cfg_corrupt_in || corrupt_r) begin
					mode_r <= mode_cfg_corrupt;
				end else begin
					mode_r <= mode_normal;
				end
			end else if (mode_r == mode_cfg_corrupt && nv_cnt_r == 16'h1) begin
				mode_r <= mode_normal;
			end
		end
	end

	// volatile status contents
	status_t status_nxt;
	always_comb begin
		case (mode_r)
			mode_init_fail: status_nxt = {1'b0, 2'h3, block_protect_size_in, 2'h1};
			mode_cfg_corrupt: status_nxt = {2'h1, 1'b0, block_protect_size_in, 2'h1};
			default: status_nxt = {wp_r, prg_r, ers_r, block_protect_size_in, wel_r,
				stuck_r | nv_busy};
		endcase
	end
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			status_r <= '0;
		end else begin
			status_r <= status_nxt;
		end
	end
	assign status_out = status_r;
	assign boot_mode_out = mode_r;

	default clocking @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);
	sequence s_last_dummy;
		frame_on && phase_r == ph_dummy && rise && dcnt_r == 2'h1;
	endsequence
	sequence s_rnd_prog;
		prog_stb && prog_rnd && !hwr_act;
	endsequence
	dummy_count_a: assert property (s_last_dummy |=> phase_r == ph_data)
		else $error("read data did not follow two latency cycles");
	rnd_prog_err_a: assert property (s_rnd_prog |=> prg_r && stuck_r ##1 status_r[6])
		else $error("program on random value gave no error");
	rnd_kept_a: assert property (prog_stb && prog_rnd |=> $stable(mem[0])
		&& $stable(mem[15]) && mem[$past(sec_a)] == $past(mem[sec_a]))
		else $error("random value area changed");
	lock_block_a: assert property (prog_stb && prog_lock && !hwr_act |=> prg_r
		&& mem[$past(sec_a)] == $past(mem[sec_a]))
		else $error("locked region was programmed");
	stall_hold_a: assert property (stuck_r && !hwr_act |=> stuck_r)
		else $error("stall left without hardware reset");
	ers_rnd_a: assert property (ers_stb && ers_rnd && !hwr_act |=> ers_r ##1 status_r[0])
		else $error("erase on random value gave no error");
	init_sig_a: assert property (mode_r == mode_init_fail |=> status_r[7:5] == 3'h3
		&& status_r[1:0] == 2'h1 && status_r[4:2] == $past(block_protect_size_in))
		else $error("init failure signature wrong");
	corrupt_sig_a: assert property (mode_r == mode_cfg_corrupt |=> status_r[7:5] == 3'h2
		&& status_r[1:0] == 2'h1 && status_r[4:2] == $past(block_protect_size_in))
		else $error("corruption signature wrong");
	single_lane_a: assert property (mode_r != mode_normal && cs_start |=> !quad_r)
		else $error("four lanes used in recovery mode");
	init_filter_a: assert property (restricted && byte_done && phase_r == ph_cmd
		&& in_byte != `OP_READ_STATUS && in_byte != `OP_READ_ANY |=> phase_r == ph_ignore)
		else $error("disallowed command accepted in restricted mode");
	abort_mark_a: assert property (hwr_act && nv_busy |=> corrupt_r && !nv_busy)
		else $error("aborted write not marked corrupt");
endmodule : secure_region_boot

/* File: sim/spi_host_model.sv */
// host side model of the serial link for the secure region bench
`timescale 1ns/1ps
`include "srbf_consts.svh"
module spi_host_model (
	input wire logic clock_in, // bench clock
	input wire logic [3:0] dev_dq_in, // device data pins
	input wire logic [3:0] dev_oe_in, // device pin enables
	output logic sck_out, // serial clock
	output logic cs_n_out, // chip select
	output logic [3:0] dq_out, // host data pins
	output logic quad_out, // four-lane frames
	output logic hw_reset_n_out // hardware reset pin
);
	logic oe_seen;
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		dq_out = 4'h0;
		quad_out = 1'b0;
		hw_reset_n_out = 1'b1;
		oe_seen = 1'b0;
	end
	// one 80 ns serial clock; unused lanes toggle, released device lanes read high
	task automatic cyc(input logic [3:0] w, output logic [3:0] r);
		@(negedge clock_in);
		sck_out = 1'b0;
		dq_out = quad_out ? w : {~dq_out[3:1], w[0]};
		repeat (4) @(negedge clock_in);
		sck_out = 1'b1;
		repeat (3) @(negedge clock_in);
		r = quad_out ? ((dev_dq_in & dev_oe_in) | ~dev_oe_in)
			: {3'h0, dev_dq_in[1] | ~dev_oe_in[1]};
		oe_seen = oe_seen | (|dev_oe_in);
	endtask : cyc
	task automatic xbyte(input logic [7:0] w, output logic [7:0] r);
		logic [3:0] a;
		logic [3:0] b;
		if (quad_out) begin
			cyc(w[7:4], a);
			cyc(w[3:0], b);
			r = {a, b};
		end else begin
			for (int i = 7; i >= 0; i--) begin
				cyc({3'h0, w[i]}, a);
				r[i] = a[0];
			end
		end
	endtask : xbyte
	task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int nadr,
		input int ndum, input logic [7:0] wd[$], input int nrd, output logic [7:0] rd[$]);
		logic [7:0] r;
		logic [3:0] d;
		rd = {};
		oe_seen = 1'b0;
		@(negedge clock_in);
		cs_n_out = 1'b0;
		xbyte(op, r);
		for (int i = 0; i < nadr; i++) xbyte(addr[31-8*i -: 8], r);
		repeat (ndum) cyc(4'h0, d);
		foreach (wd[i]) xbyte(wd[i], r);
		repeat (nrd) begin
			xbyte(8'hFF, r);
			rd.push_back(r);
		end
		@(negedge clock_in);
		sck_out = 1'b0;
		repeat (2) @(negedge clock_in);
		cs_n_out = 1'b1;
		repeat (8) @(negedge clock_in);
	endtask : frame
	task automatic hw_reset();
		@(negedge clock_in);
		hw_reset_n_out = 1'b0;
		repeat (4) @(negedge clock_in);
		hw_reset_n_out = 1'b1;
		repeat (8) @(negedge clock_in);
	endtask : hw_reset
	// status poll walks from four lanes down to one
	task automatic poll(output logic [7:0] st);
		logic [7:0] rd[$];
		logic [7:0] nd[$];
		quad_out = 1'b1;
		frame(`OP_READ_ANY, `STATUS_VOL_ADDR, 4, `READ_LATENCY, nd, 1, rd);
		if (!oe_seen) begin
			quad_out = 1'b0;
			frame(`OP_READ_ANY, `STATUS_VOL_ADDR, 4, `READ_LATENCY, nd, 1, rd);
		end
		st = rd[0];
	endtask : poll
endmodule : spi_host_model

/* File: sim/secure_region_boot_test.sv */
// self-checking bench for the secure region and boot recovery block
`timescale 1ns/1ps
`include "srbf_consts.svh"
module secure_region_boot_test;
	import srbf_pkg::*;
	localparam logic [127:0] RND = 128'h1234_5678_9ABC_DEF0_0FED_CBA9_8765_4321;
	localparam logic [2:0] BP = 3'h5;
	logic clock_in = 1'b0;
	logic rst_n = 1'b0;
	logic init_fail = 1'b0;
	logic cfg_bad = 1'b0;
	logic hw_n, sck, cs_n, quad;
	logic [3:0] dq, dqo, oe;
	status_t st;
	boot_mode_t mode;
	logic [7:0] q[$];
	logic [7:0] none[$];
	int err_count = 0;
	int cmp_count = 0;
	always #5 clock_in = ~clock_in;
	secure_region_boot #(.RANDOM_VALUE(RND), .NV_WRITE_CYCLES(60)) i_dut (
		.clock_in(clock_in), .rst_n_in(rst_n), .hw_reset_n_in(hw_n), .sck_in(sck),
		.cs_n_in(cs_n), .dq_in(dq), .quad_mode_in(quad), .init_fail_in(init_fail),
		.cfg_corrupt_in(cfg_bad), .block_protect_size_in(BP), .dq_out(dqo),
		.dq_oe_out(oe), .status_out(st), .boot_mode_out(mode));
	spi_host_model i_host (.clock_in(clock_in), .dev_dq_in(dqo), .dev_oe_in(oe),
		.sck_out(sck), .cs_n_out(cs_n), .dq_out(dq), .quad_out(quad),
		.hw_reset_n_out(hw_n));
	task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	function automatic logic [7:0] sig(input logic p, input logic e, input logic b);
		return {1'b0, p, e, BP, 1'b0, b};
	endfunction : sig
	task automatic rdsec(input logic [31:0] a, input int n);
		i_host.frame(`OP_READ_SECURE, a, 4, `READ_LATENCY, none, n, q);
	endtask : rdsec
	task automatic cmd(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d,
		input int nd);
		logic [7:0] w[$];
		if (nd > 0) w.push_back(d);
		i_host.frame(`OP_WRITE_ENABLE, 32'h0, 0, 0, none, 0, q);
		i_host.frame(op, a, 4, 0, w, 0, q);
	endtask : cmd
	task automatic t_random();
		rdsec(32'h0, 16);
		for (int i = 0; i < 16; i++) check("random byte", q[i], RND[8*i +: 8]);
		rdsec(32'h400, 1);
		check("wrapped byte", q[0], RND[7:0]);
		i_host.quad_out = 1'b1;
		rdsec(32'h1, 1);
		check("quad byte", q[0], RND[15:8]);
		i_host.quad_out = 1'b0;
		$display("done random read");
	endtask : t_random
	task automatic t_lock();
		cmd(`OP_PROG_SECURE, 32'h20, 8'hA5, 1);
		rdsec(32'h20, 1);
		check("programmed byte", q[0], 8'hA5);
		cmd(`OP_PROG_SECURE, 32'h10, 8'hFD, 1);
		rdsec(32'h10, 1);
		check("lock byte", q[0], 8'hFD);
		cmd(`OP_PROG_SECURE, 32'h21, 8'h00, 1);
		rdsec(32'h21, 1);
		check("locked byte", q[0], 8'hFF);
		check("lock error", st, sig(1, 0, 0));
		cmd(`OP_PROG_SECURE, 32'h40, 8'h3C, 1);
		rdsec(32'h40, 1);
		check("open region", q[0], 8'h3C);
		i_host.hw_reset();
		$display("done region locks");
	endtask : t_lock
	task automatic t_guard();
		cmd(`OP_PROG_SECURE, 32'h5, 8'h00, 1);
		check("program guard", st, sig(1, 0, 1));
		rdsec(32'h20, 1);
		check("stalled read", i_host.oe_seen, 1'b0);
		i_host.frame(`OP_READ_STATUS, 32'h0, 0, 0, none, 1, q);
		check("status read", q[0], sig(1, 0, 1));
		i_host.hw_reset();
		cmd(`OP_ERASE_SECURE, 32'h3, 8'h00, 0);
		check("erase guard", st, sig(0, 1, 1));
		i_host.hw_reset();
		check("after reset", st, sig(0, 0, 0));
		rdsec(32'h0, 16);
		for (int i = 0; i < 16; i++) check("kept random", q[i], RND[8*i +: 8]);
		$display("done random guard");
	endtask : t_guard
	task automatic t_init();
		logic [7:0] s;
		init_fail = 1'b1;
		i_host.hw_reset();
		check("init mode", mode, mode_init_fail);
		check("init signature", st, sig(1, 1, 1));
		i_host.poll(s);
		check("polled status", s, sig(1, 1, 1));
		check("one lane", i_host.quad_out, 1'b0);
		rdsec(32'h0, 1);
		check("refused read", i_host.oe_seen, 1'b0);
		init_fail = 1'b0;
		i_host.hw_reset();
		check("normal mode", mode, mode_normal);
		$display("done init failure");
	endtask : t_init
	task automatic rewrite();
		int n;
		cmd(`OP_WRITE_ANY, 32'h2, 8'h00, 1);
		n = 0;
		while (mode !== mode_normal && n < 300) begin
			@(negedge clock_in);
			n++;
		end
		check("rewritten", mode, mode_normal);
	endtask : rewrite
	task automatic t_corrupt();
		cfg_bad = 1'b1;
		i_host.hw_reset();
		cfg_bad = 1'b0;
		check("corrupt mode", mode, mode_cfg_corrupt);
		check("corrupt signature", st, sig(1, 0, 1));
		rdsec(32'h0, 1);
		check("corrupt read", q[0], RND[7:0]);
		cmd(`OP_WRITE_ANY, `STATUS_VOL_ADDR, 8'h80, 1);
		check("corrupt status", st, sig(1, 0, 1));
		rewrite();
		cmd(`OP_WRITE_ANY, 32'h2, 8'h00, 1);
		i_host.hw_reset();
		check("aborted write", mode, mode_cfg_corrupt);
		rewrite();
		repeat (2) @(negedge clock_in);
		check("status write", st, sig(0, 0, 0) | 8'h80);
		$display("done config corruption");
	endtask : t_corrupt
	task automatic finish_test();
		$display("checks %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	initial begin
		repeat (3) @(negedge clock_in);
		rst_n = 1'b1;
		repeat (6) @(negedge clock_in);
		t_random();
		t_lock();
		t_guard();
		t_init();
		t_corrupt();
		finish_test();
	end
	initial begin
		#900000;
		err_count++;
		$display("ERROR watchdog expected done seen timeout");
		finish_test();
	end
endmodule : secure_region_boot_test
